// [design/cwcs_pkg.sv]
package cwcs_pkg;
  // clock and oscillator rates
  localparam int CLK_MHZ = 125;
  localparam int CLK_HZ = 125_000_000;
  localparam int FAST_OSC_HZ = 16_000_000;
  localparam int SLOW_OSC_HZ = 31_000;
  localparam int FAST_DIV = CLK_HZ / FAST_OSC_HZ;
  localparam int SLOW_DIV = CLK_HZ / SLOW_OSC_HZ;
  // oscillator start-up times
  localparam int READY_NS = 2000;
  localparam int READY_CYC = (READY_NS * CLK_MHZ + 999) / 1000;
  localparam int STABLE_NS = 200000;
  localparam int STABLE_CYC = (STABLE_NS * CLK_MHZ + 999) / 1000;
  // register indices, byte address is four times the index
  localparam logic [13:0] IDX_USER0 = 14'h2000;
  localparam logic [13:0] IDX_USER3 = 14'h2003;
  localparam logic [13:0] IDX_PARTID = 14'h2006;
  localparam logic [13:0] IDX_CONFIG = 14'h2007;
  localparam logic [13:0] IDX_OSCCTL = 14'h0010;
  localparam logic [13:0] IDX_DOGCTL = 14'h0011;
  localparam logic [13:0] IDX_SDCTL = 14'h0012;
  localparam logic [13:0] IDX_STATUS = 14'h0013;
  // configuration word fields
  localparam int CFG_CLKSRC = 0;
  localparam int CFG_SD_LO = 1;
  localparam int CFG_DOG_LO = 3;
  localparam int CFG_PWRUP = 5;
  localparam int CFG_CP = 7;
  localparam int CFG_WRT_LO = 12;
  // oscillator control fields
  localparam int OSC_FREQ_LO = 4;
  localparam int OSC_READY = 3;
  localparam int OSC_LREADY = 1;
  localparam int OSC_STABLE = 0;
  localparam logic [2:0] FREQ_RESET = 3'h6;
  localparam logic [2:0] FREQ_SLOW = 3'h0;
  localparam int SW_EN_BIT = 0;
  localparam logic [13:0] USER_RESET = 14'h0000;
  // identification, values arbitrary
  localparam logic [8:0] PART_CODE = 9'h0a5;
  localparam logic [4:0] REV_CODE = 5'h01;
  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_SW = 2'h1,
    MODE_RUN = 2'h2,
    MODE_ON = 2'h3
  } cwcs_mode_t;
  typedef enum logic [2:0] {
    OSC_START = 3'h1,
    OSC_UP = 3'h2,
    OSC_FINE = 3'h4
  } cwcs_osc_t;
  typedef struct packed {
    logic powerupEn;
    logic dogEn;
    logic supplyDropEn;
    logic extClockMode;
    logic clkPinGpio;
    logic progProtect;
    logic dataProtect;
    logic [1:0] guardSize;
  } cwcs_ctrl_t;
endpackage : cwcs_pkg

// [design/cwcs_top.sv]
// What this block does
// - power-up delay timer enabled when its config bit is 0, disabled when 1.
// - supply-drop reset enable never turns on the power-up delay timer.
// - dog mode 11 on, 10 on unless asleep, 01 software bit, 00 off.
// - supply-drop mode decodes like the dog; software bit only counts in 01.
// - clock source bit 1 takes external pin clock, 0 internal and pin is I/O.
// - code protect low blocks external writes; external reads return zeros.
// - CPU reads of program memory are never affected by protection.
// - code protect, once on, clears only by bulk erase.
// - program and data memory protection are separate settings.
// - write guard field sizes the region guarded against self-writes.
// - four user words at 2000h-2003h are readable and writable.
// - identity word at 2006h: part code bits 13-5, revision bits 4-0.
// - identity word is read-only; writes leave it unchanged.
// - two internal oscillators, 16 MHz and 31 kHz, make all internal clocks.
// - fast oscillator ready flag rises when its quick secondary clock runs.
// - fast oscillator stable flag rises when its accurate primary clock settles.
// - frequency select picks 16M down to 250k from fast, or 31k from slow.
// - frequency select loads 110, 8 MHz, on any reset; software may change it.
// - switching between fast divider settings takes effect with no delay.
// - select codes 111 16M, 110 8M, down to 001 250k, 000 31k.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
module cwcs_top #(
  parameter int STABLE_CYCLES = cwcs_pkg::STABLE_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  // nonvolatile configuration cell
  input wire logic [13:0] nvWord,
  input wire logic dataProtNvN,
  output logic nvWrReq_q,
  output logic [13:0] nvWrData_q,
  // power state and clock pin
  input wire logic sleeping,
  input wire logic clkPin,
  output cwcs_pkg::cwcs_ctrl_t ctrl_q,
  output logic sysClkEn_q,
  // external programmer path
  input wire logic extWrReq,
  input wire logic [13:0] extRdData,
  output logic extWrAllow_q,
  output logic [13:0] extRdOut_q,
  // cpu self-write path
  input wire logic selfWrReq,
  input wire logic [8:0] selfWrAddr,
  output logic selfWrAllow_q
);

  function automatic logic modeOn(input cwcs_pkg::cwcs_mode_t m, input logic sw,
                                  input logic slp);
    case (m)
      cwcs_pkg::MODE_ON: modeOn = 1'b1;
      cwcs_pkg::MODE_RUN: modeOn = !slp;
      cwcs_pkg::MODE_SW: modeOn = sw;
      default: modeOn = 1'b0;
    endcase
  endfunction : modeOn

  function automatic logic [5:0] divMask(input logic [2:0] s);
    logic [5:0] m;
    m = 6'h00;
    for (int i = 0; i < 6; i++) begin
      if (i < 7 - int'(s)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : divMask

  function automatic logic [8:0] guardTop(input logic [1:0] g);
    case (g)
      2'h2: guardTop = 9'h07f;
      2'h1: guardTop = 9'h0ff;
      2'h0: guardTop = 9'h1ff;
      default: guardTop = 9'h000;
    endcase
  endfunction : guardTop

  // configuration sample
  logic cfgLoaded_q;
  logic [13:0] cfg_q;
  logic dataProtN_q;
  logic swDog_q;
  logic swDrop_q;
  logic [2:0] freq_q;
  logic [13:0] userId_q [4];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cfgLoaded_q <= 1'b0;
      cfg_q <= 14'h3fff;
      dataProtN_q <= 1'b1;
    end else if (!cfgLoaded_q) begin
      cfgLoaded_q <= 1'b1;
      cfg_q <= nvWord;
      dataProtN_q <= dataProtNvN;
    end
  end

  cwcs_pkg::cwcs_mode_t dogMode;
  cwcs_pkg::cwcs_mode_t dropMode;
  assign dogMode = cwcs_pkg::cwcs_mode_t'(cfg_q[cwcs_pkg::CFG_DOG_LO +: 2]);
  assign dropMode = cwcs_pkg::cwcs_mode_t'(cfg_q[cwcs_pkg::CFG_SD_LO +: 2]);

  // decoded controls
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= '{progProtect: 1'b1, dataProtect: 1'b1, default: '0};
    end else begin
      ctrl_q.powerupEn <= cfgLoaded_q && !cfg_q[cwcs_pkg::CFG_PWRUP];
      ctrl_q.dogEn <= cfgLoaded_q && modeOn(dogMode, swDog_q, sleeping);
      ctrl_q.supplyDropEn <= cfgLoaded_q && modeOn(dropMode, swDrop_q, sleeping);
      ctrl_q.extClockMode <= cfgLoaded_q && cfg_q[cwcs_pkg::CFG_CLKSRC];
      ctrl_q.clkPinGpio <= cfgLoaded_q && !cfg_q[cwcs_pkg::CFG_CLKSRC];
      ctrl_q.progProtect <= !cfgLoaded_q || !cfg_q[cwcs_pkg::CFG_CP];
      ctrl_q.dataProtect <= !cfgLoaded_q || !dataProtN_q;
      ctrl_q.guardSize <= cfg_q[cwcs_pkg::CFG_WRT_LO +: 2];
    end
  end

  // external and self-write gating; cpu read path bypasses this block
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      extWrAllow_q <= 1'b0;
      extRdOut_q <= 14'h0000;
      selfWrAllow_q <= 1'b0;
    end else begin
      extWrAllow_q <= extWrReq && !ctrl_q.progProtect;
      extRdOut_q <= ctrl_q.progProtect ? 14'h0000 : extRdData;
      selfWrAllow_q <= selfWrReq && cfgLoaded_q &&
                       (ctrl_q.guardSize == 2'h3 ||
                        selfWrAddr > guardTop(ctrl_q.guardSize));
    end
  end

  // oscillator models
  logic [12:0] fastCnt_q;
  logic [12:0] slowCnt_q;
  logic fastTick;
  logic slowTick;
  logic slowReady_q;
  assign fastTick = fastCnt_q == 13'(cwcs_pkg::FAST_DIV - 1);
  assign slowTick = slowCnt_q == 13'(cwcs_pkg::SLOW_DIV - 1);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fastCnt_q <= 13'h0000;
      slowCnt_q <= 13'h0000;
      slowReady_q <= 1'b0;
    end else begin
      fastCnt_q <= fastTick ? 13'h0000 : fastCnt_q + 13'h0001;
      slowCnt_q <= slowTick ? 13'h0000 : slowCnt_q + 13'h0001;
      if (slowTick) begin
        slowReady_q <= 1'b1;
      end
    end
  end

  cwcs_pkg::cwcs_osc_t oscState_q;
  logic [31:0] upCnt_q;
  logic oscReady;
  logic oscStable;
  assign oscReady = oscState_q != cwcs_pkg::OSC_START;
  assign oscStable = oscState_q == cwcs_pkg::OSC_FINE;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      oscState_q <= cwcs_pkg::OSC_START;
      upCnt_q <= 32'h0000_0000;
    end else begin
      upCnt_q <= upCnt_q + 32'h0000_0001;
      case (oscState_q)
        cwcs_pkg::OSC_START: begin
          if (upCnt_q == 32'(cwcs_pkg::READY_CYC - 1)) begin
            oscState_q <= cwcs_pkg::OSC_UP;
            upCnt_q <= 32'h0000_0000;
          end
        end
        cwcs_pkg::OSC_UP: begin
          if (upCnt_q == 32'(STABLE_CYCLES - 1)) begin
            oscState_q <= cwcs_pkg::OSC_FINE;
          end
        end
        cwcs_pkg::OSC_FINE: begin
          upCnt_q <= upCnt_q;
        end
        default: begin
          oscState_q <= cwcs_pkg::OSC_START;
        end
      endcase
    end
  end

  // divider and multiplexer; counter free runs so a new select acts at once
  logic [5:0] divCnt_q;
  logic intTick;
  assign intTick = (freq_q == cwcs_pkg::FREQ_SLOW) ? slowTick && slowReady_q :
                   fastTick && oscReady &&
                   ((divCnt_q & divMask(freq_q)) == 6'h00);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      divCnt_q <= 6'h00;
    end else if (fastTick && oscReady) begin
      divCnt_q <= divCnt_q + 6'h01;
    end
  end

  // external clock pin
  logic pinMeta_q;
  logic pinSync_q;
  logic pinLast_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta_q <= 1'b0;
      pinSync_q <= 1'b0;
      pinLast_q <= 1'b0;
      sysClkEn_q <= 1'b0;
    end else begin
      pinMeta_q <= clkPin;
      pinSync_q <= pinMeta_q;
      pinLast_q <= pinSync_q;
      sysClkEn_q <= ctrl_q.extClockMode ? pinSync_q && !pinLast_q :
                    ctrl_q.clkPinGpio && intTick;
    end
  end

  // apb decode
  logic [13:0] idx;
  logic setup;
  logic wrEn;
  logic [31:0] rdVal;
  logic rdErr;
  assign idx = paddr[15:2];
  assign setup = psel && !penable;
  assign wrEn = psel && penable && pready_q && pwrite && !pslverr_q;

  always_comb begin
    rdVal = 32'h0000_0000;
    rdErr = paddr[1:0] != 2'h0;
    if (idx >= cwcs_pkg::IDX_USER0 && idx <= cwcs_pkg::IDX_USER3) begin
      rdVal[13:0] = userId_q[idx[1:0]];
    end else begin
      case (idx)
        cwcs_pkg::IDX_PARTID: rdVal[13:0] = {cwcs_pkg::PART_CODE,
                                             cwcs_pkg::REV_CODE};
        cwcs_pkg::IDX_CONFIG: rdVal[13:0] = cfg_q;
        cwcs_pkg::IDX_OSCCTL: begin
          rdVal[cwcs_pkg::OSC_FREQ_LO +: 3] = freq_q;
          rdVal[cwcs_pkg::OSC_READY] = oscReady;
          rdVal[cwcs_pkg::OSC_LREADY] = slowReady_q;
          rdVal[cwcs_pkg::OSC_STABLE] = oscStable;
        end
        cwcs_pkg::IDX_DOGCTL: rdVal[cwcs_pkg::SW_EN_BIT] = swDog_q;
        cwcs_pkg::IDX_SDCTL: rdVal[cwcs_pkg::SW_EN_BIT] = swDrop_q;
        cwcs_pkg::IDX_STATUS: rdVal[8:0] = ctrl_q;
        default: rdErr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && rdErr;
      if (setup && !pwrite && !rdErr) begin
        prdata_q <= rdVal;
      end else if (setup) begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // software registers; identity word has no write path
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      freq_q <= cwcs_pkg::FREQ_RESET;
      swDog_q <= 1'b0;
      swDrop_q <= 1'b0;
    end else if (wrEn) begin
      case (idx)
        cwcs_pkg::IDX_OSCCTL: freq_q <= pwdata[cwcs_pkg::OSC_FREQ_LO +: 3];
        cwcs_pkg::IDX_DOGCTL: swDog_q <= pwdata[cwcs_pkg::SW_EN_BIT];
        cwcs_pkg::IDX_SDCTL: swDrop_q <= pwdata[cwcs_pkg::SW_EN_BIT];
        default: swDog_q <= swDog_q;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        userId_q[i] <= cwcs_pkg::USER_RESET;
      end
    end else if (wrEn && idx >= cwcs_pkg::IDX_USER0 && idx <= cwcs_pkg::IDX_USER3) begin
      userId_q[idx[1:0]] <= pwdata[13:0];
    end
  end

  // config rewrite to the nonvolatile cell, protect bit cannot be raised
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      nvWrReq_q <= 1'b0;
      nvWrData_q <= 14'h3fff;
    end else begin
      nvWrReq_q <= wrEn && idx == cwcs_pkg::IDX_CONFIG;
      if (wrEn && idx == cwcs_pkg::IDX_CONFIG) begin
        nvWrData_q <= pwdata[13:0];
        nvWrData_q[cwcs_pkg::CFG_CP] <= pwdata[cwcs_pkg::CFG_CP] &&
                                        nvWord[cwcs_pkg::CFG_CP];
      end
    end
  end

  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  sequence cfgWrite;
    wrEn && idx == cwcs_pkg::IDX_CONFIG;
  endsequence

  sequence oscWrite;
    wrEn && idx == cwcs_pkg::IDX_OSCCTL;
  endsequence

  cfg_hold_a: assert property (cfgLoaded_q |=> $stable(cfg_q) && cfgLoaded_q)
    else $error("sampled configuration changed");
  pwrup_indep_a: assert property (cfgLoaded_q && cfg_q[cwcs_pkg::CFG_PWRUP] |=>
    !ctrl_q.powerupEn) else $error("power-up timer enabled by other field");
  dog_off_a: assert property (cfgLoaded_q && dogMode == cwcs_pkg::MODE_OFF |=>
    !ctrl_q.dogEn) else $error("dog enabled in off mode");
  drop_ignore_a: assert property (cfgLoaded_q && dropMode == cwcs_pkg::MODE_ON |=>
    ctrl_q.supplyDropEn) else $error("supply drop not forced on");
  ext_block_a: assert property (ctrl_q.progProtect |=>
    !extWrAllow_q && extRdOut_q == 14'h0000) else $error("protected access leaked");
  cp_sticky_a: assert property (cfgWrite ##0 !nvWord[cwcs_pkg::CFG_CP] |=>
    nvWrReq_q && !nvWrData_q[cwcs_pkg::CFG_CP]) else $error("protect bit raised");
  part_read_a: assert property (setup && !pwrite && idx == cwcs_pkg::IDX_PARTID
    && paddr[1:0] == 2'h0 |=> prdata_q[13:0] == {cwcs_pkg::PART_CODE, cwcs_pkg::REV_CODE})
    else $error("identity word wrong");
  freq_hold_a: assert property (!(wrEn && idx == cwcs_pkg::IDX_OSCCTL) |=>
    $stable(freq_q)) else $error("frequency select changed without write");
  freq_write_a: assert property (oscWrite |=>
    freq_q == $past(pwdata[cwcs_pkg::OSC_FREQ_LO +: 3]))
    else $error("frequency select write lost");
  freq_reset_a: assert property ($rose(cfgLoaded_q) |->
    freq_q == cwcs_pkg::FREQ_RESET) else $error("frequency select not 8 MHz after reset");
  ready_order_a: assert property (oscStable |-> oscReady ##1 oscReady)
    else $error("stable before ready");
  fast_tick_a: assert property (ctrl_q.clkPinGpio && freq_q == 3'h7 &&
    fastTick && oscReady |=> sysClkEn_q) else $error("16 MHz tick missed");

endmodule : cwcs_top

// [verification/cwcs_prog_model.sv]
`timescale 1ns/100ps
module cwcs_prog_model (
  // clock
  input wire logic clock,
  // programmer access path
  output logic extWrReq,
  output logic [13:0] extRdData
);
  initial begin
    extWrReq = 1'b0;
    extRdData = 14'h2aaa;
  end
  // one programmer access, launched just after a clock edge and held until the next put
  task automatic put(input logic wr, input logic [13:0] d);
    @(posedge clock);
    extWrReq <= wr;
    extRdData <= d;
  endtask : put
endmodule : cwcs_prog_model

// [verification/tb_config_word_and_clock_select.sv]
`timescale 1ns/100ps
module tb_config_word_and_clock_select;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [13:0] nvWord = 14'h2012;
  logic dataProtNvN = 1'b1;
  logic nvWrReq_q;
  logic [13:0] nvWrData_q;
  logic sleeping = 1'b0;
  logic clkPin = 1'b0;
  cwcs_pkg::cwcs_ctrl_t ctrl_q;
  logic sysClkEn_q;
  logic extWrReq;
  logic [13:0] extRdData;
  logic extWrAllow_q;
  logic [13:0] extRdOut_q;
  logic selfWrReq = 1'b0;
  logic [8:0] selfWrAddr = 9'h000;
  logic selfWrAllow_q;
  int err_total = 0;
  int check_count = 0;
  logic [31:0] rd;
  logic er;

  always #4 clock = ~clock;

  cwcs_top #(.STABLE_CYCLES(50)) u_dut (
    .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .nvWord(nvWord), .dataProtNvN(dataProtNvN),
    .nvWrReq_q(nvWrReq_q), .nvWrData_q(nvWrData_q), .sleeping(sleeping),
    .clkPin(clkPin), .ctrl_q(ctrl_q), .sysClkEn_q(sysClkEn_q), .extWrReq(extWrReq),
    .extRdData(extRdData), .extWrAllow_q(extWrAllow_q), .extRdOut_q(extRdOut_q),
    .selfWrReq(selfWrReq), .selfWrAddr(selfWrAddr), .selfWrAllow_q(selfWrAllow_q)
  );

  cwcs_prog_model u_prog (.clock(clock), .extWrReq(extWrReq), .extRdData(extRdData));

  // external clock pin, one rising edge every ten clocks
  always begin
    repeat (5) @(posedge clock);
    clkPin <= ~clkPin;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [13:0] idx, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready_q !== 1'b1) @(posedge clock);
    rd = prdata_q;
    er = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rst(input logic [13:0] nv, input logic dp);
    @(posedge clock);
    arst_n <= 1'b0;
    nvWord <= nv;
    dataProtNvN <= dp;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
  endtask : rst

  // edges from one system clock enable pulse to the next
  // two edges are skipped first so a pulse of the old select is never taken
  task automatic per(input int e);
    int n;
    n = 0;
    repeat (2) @(posedge clock);
    while (sysClkEn_q !== 1'b1 && n < 10000) begin
      @(posedge clock);
      n++;
    end
    @(posedge clock);
    n = 1;
    while (sysClkEn_q !== 1'b1 && n < 10000) begin
      @(posedge clock);
      n++;
    end
    chk(n, e);
  endtask : per

  task automatic t_osc_flags;
    apb(1'b0, cwcs_pkg::IDX_OSCCTL, 32'h0);
    chk(rd & 32'h7d, 32'h60);
    repeat (260) @(posedge clock);
    apb(1'b0, cwcs_pkg::IDX_OSCCTL, 32'h0);
    chk(rd & 32'h7d, 32'h68);
    repeat (60) @(posedge clock);
    apb(1'b0, cwcs_pkg::IDX_OSCCTL, 32'h0);
    chk(rd & 32'h7d, 32'h69);
  endtask : t_osc_flags

  task automatic t_regs;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, cwcs_pkg::IDX_USER0 + 14'(i), 32'h1230 + i);
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, cwcs_pkg::IDX_USER0 + 14'(i), 32'h0);
      chk(rd, 32'h1230 + i);
    end
    apb(1'b1, cwcs_pkg::IDX_PARTID, 32'h0);
    chk(er, 1'b0);
    apb(1'b0, cwcs_pkg::IDX_PARTID, 32'h0);
    chk(rd, 32'h14a1);
    apb(1'b0, 14'h0020, 32'h0);
    chk(er, 1'b1);
  endtask : t_regs

  task automatic t_cfg_a;
    chk(ctrl_q, 9'h19a);
    u_prog.put(1'b1, 14'h1555);
    repeat (2) @(posedge clock);
    chk(extWrAllow_q, 1'b0);
    chk(extRdOut_q, 14'h0000);
    apb(1'b1, cwcs_pkg::IDX_CONFIG, 32'h3fff);
    @(posedge clock);
    chk(nvWrReq_q, 1'b1);
    chk(nvWrData_q, 14'h3f7f);
    apb(1'b1, cwcs_pkg::IDX_SDCTL, 32'h1);
    repeat (2) @(posedge clock);
    chk(ctrl_q, 9'h1da);
    sleeping <= 1'b1;
    repeat (3) @(posedge clock);
    chk(ctrl_q, 9'h15a);
    sleeping <= 1'b0;
    selfWrReq <= 1'b1;
    selfWrAddr <= 9'h07f;
    repeat (2) @(posedge clock);
    chk(selfWrAllow_q, 1'b0);
    selfWrAddr <= 9'h080;
    repeat (2) @(posedge clock);
    chk(selfWrAllow_q, 1'b1);
  endtask : t_cfg_a

  task automatic t_freq;
    for (int c = 7; c > 0; c--) begin
      apb(1'b1, cwcs_pkg::IDX_OSCCTL, 32'(c) << 4);
      per(7 << (7 - c));
    end
    apb(1'b1, cwcs_pkg::IDX_OSCCTL, 32'h0);
    per(4032);
  endtask : t_freq

  task automatic t_cfg_b;
    chk(ctrl_q, 9'h067);
    apb(1'b1, cwcs_pkg::IDX_DOGCTL, 32'h1);
    apb(1'b1, cwcs_pkg::IDX_SDCTL, 32'h0);
    repeat (2) @(posedge clock);
    chk(ctrl_q, 9'h0e7);
    u_prog.put(1'b1, 14'h1555);
    repeat (2) @(posedge clock);
    chk(extWrAllow_q, 1'b1);
    chk(extRdOut_q, 14'h1555);
    selfWrAddr <= 9'h000;
    repeat (2) @(posedge clock);
    chk(selfWrAllow_q, 1'b1);
    per(10);
  endtask : t_cfg_b

  initial begin
    rst(14'h2012, 1'b1);
    t_osc_flags();
    t_regs();
    t_cfg_a();
    t_freq();
    rst(14'h30af, 1'b0);
    t_cfg_b();
    report_and_stop();
  end

  initial begin
    repeat (60000) @(posedge clock);
    err_total++;
    report_and_stop();
  end
endmodule : tb_config_word_and_clock_select
